/* hdl/dhp_defines.vh */
// Constants shared by the DMA handshake port design files.
`ifndef DHP_DEFINES_VH
`define DHP_DEFINES_VH
`define DHP_MODE_HANDSHAKE 2'h0
`define DHP_MODE_EXTERNAL 2'h1
`define DHP_MODE_PACED 2'h2
`define DHP_ADDR_W 25
`define DHP_SEL_W 4
`define DHP_DATA_W 32
`define DHP_FIFO_DEPTH 32
`define DHP_FIFO_AW 5
`define DHP_ADDR_RESET 25'h0000000
`define DHP_SEL_RESET 4'hF
`define DHP_CLK_PERIOD_NS 100
`define DHP_CLKDIV_HALF 8'h01
`define DHP_BURST_CYCLES 1
`endif

/* hdl/dhp_sync.v */
// Two flip-flop synchroniser for the request pin input of the DMA handshake port.
`timescale 1ns/1ns
`default_nettype none
module dhp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clock,
  input wire rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage1_r;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_r <= INIT;
      dout <= INIT;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule // dhp_sync
`default_nettype wire

/* hdl/dhp_fifo.v */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module dhp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire full;
  wire empty;
  wire push;
  wire pop;
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign empty = (wrPtr_r == rdPtr_r);
  assign inReady = ~full;
  assign outValid = ~empty;
  assign push = inValid & ~full;
  assign pop = outReady & ~empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule // dhp_fifo
`default_nettype wire

/* hdl/dhp_port.v */
// DMA handshake port: request sampling, grant and strobe sequencing, write and read data FIFOs.
`include "dhp_defines.vh"
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Transfers start only after request goes low.
// - Handshake mode drives grant to move data.
// - External mode uses address, strobes, selects, grant.
// - Paced mode never asserts grant.
// - Paced mode follows normal bus master cycles.
// - Request held low stalls handshake write completion.
// - Request held low extends read per cycle; here only in handshake and external modes, paced reads end on acknowledge.
// - Request sampled on falling bus clock output edges.
// - Synchronous mode strobe rises with grant end.
module dhp_port (
  input wire clock,
  input wire rst,
  input wire [1:0] mode,
  input wire xferWrite,
  input wire [`DHP_ADDR_W-1:0] xferAddr,
  input wire [`DHP_SEL_W-1:0] xferSelect,
  input wire dma_request_n,
  input wire ack,
  input wire [`DHP_DATA_W-1:0] busDataIn,
  output reg [`DHP_DATA_W-1:0] busDataOut,
  output reg busDataOe,
  output reg [`DHP_ADDR_W-1:0] addrOut,
  output reg [`DHP_SEL_W-1:0] memory_select_n,
  output reg rdN,
  output reg wrN,
  output reg dma_grant_n,
  output reg bus_clock_output,
  input wire [`DHP_DATA_W-1:0] wrData,
  input wire wrValid,
  output wire wrReady,
  output wire [`DHP_DATA_W-1:0] rdData,
  output wire rdValid,
  input wire rdReady,
  output reg busy
);
  // ****************************************************************
  // Bus clock output divider and edge enable.
  // ****************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_XFER = 2'h1;
  localparam ST_HOLD = 2'h2;
  localparam ST_DONE = 2'h3;
  reg [7:0] divCnt_r;
  wire busEdge;
  assign busEdge = (divCnt_r == `DHP_CLKDIV_HALF) & bus_clock_output;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      divCnt_r <= 8'h00;
      bus_clock_output <= 1'b0;
    end else if (divCnt_r == `DHP_CLKDIV_HALF) begin
      divCnt_r <= 8'h00;
      bus_clock_output <= ~bus_clock_output;
    end else begin
      divCnt_r <= divCnt_r + 8'h01;
    end
  end

  // ****************************************************************
  // Request synchroniser.
  // ****************************************************************
  wire reqSync;
  reg reqPrev_r;
  dhp_sync #(.W(1), .INIT(1'b1)) uReqSync (
    .clock(clock),
    .rst(rst),
    .din(dma_request_n),
    .dout(reqSync)
  );
  wire reqLow;
  assign reqLow = ~reqSync;

  // ****************************************************************
  // Data buffers.
  // ****************************************************************
  wire [`DHP_DATA_W-1:0] txData;
  wire txValid;
  wire txPop;
  wire rxReady;
  reg rxPush;
  reg [`DHP_DATA_W-1:0] rxData_r;
  dhp_fifo #(.WIDTH(`DHP_DATA_W), .DEPTH(`DHP_FIFO_DEPTH), .AW(`DHP_FIFO_AW)) uTxFifo (
    .clock(clock),
    .rst(rst),
    .inData(wrData),
    .inValid(wrValid),
    .inReady(wrReady),
    .outData(txData),
    .outValid(txValid),
    .outReady(txPop)
  );
  dhp_fifo #(.WIDTH(`DHP_DATA_W), .DEPTH(`DHP_FIFO_DEPTH), .AW(`DHP_FIFO_AW)) uRxFifo (
    .clock(clock),
    .rst(rst),
    .inData(rxData_r),
    .inValid(rxPush),
    .inReady(rxReady),
    .outData(rdData),
    .outValid(rdValid),
    .outReady(rdReady)
  );

  // ****************************************************************
  // Transfer sequencer.
  // ****************************************************************
  reg [1:0] state_r;
  reg isWrite_r;
  reg [1:0] mode_r;
  reg popPulse_r;
  wire canStart;
  assign txPop = popPulse_r;
  assign canStart = xferWrite ? txValid : rxReady;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      isWrite_r <= 1'b0;
      mode_r <= `DHP_MODE_HANDSHAKE;
      reqPrev_r <= 1'b1;
      addrOut <= `DHP_ADDR_RESET;
      memory_select_n <= `DHP_SEL_RESET;
      rdN <= 1'b1;
      wrN <= 1'b1;
      dma_grant_n <= 1'b1;
      busDataOut <= {`DHP_DATA_W{1'b0}};
      busDataOe <= 1'b0;
      rxData_r <= {`DHP_DATA_W{1'b0}};
      rxPush <= 1'b0;
      popPulse_r <= 1'b0;
      busy <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      popPulse_r <= 1'b0;
      if (busEdge) begin
        reqPrev_r <= reqSync;
        case (state_r)
          ST_IDLE: begin
            // A falling request edge, seen at a bus clock edge, starts a transfer.
            if (reqLow && reqPrev_r && canStart) begin
              state_r <= ST_XFER;
              isWrite_r <= xferWrite;
              mode_r <= mode;
              busy <= 1'b1;
              if (mode != `DHP_MODE_HANDSHAKE) begin
                addrOut <= xferAddr;
                memory_select_n <= xferSelect;
              end
              if (xferWrite) begin
                wrN <= 1'b0;
                busDataOut <= txData;
                busDataOe <= 1'b1;
              end else begin
                rdN <= 1'b0;
              end
              // Grant pairs with the strobe for the whole access, never in paced mode.
              dma_grant_n <= (mode == `DHP_MODE_PACED);
            end
          end
          ST_XFER: begin
            // Paced mode waits on acknowledge like a normal bus master cycle.
            if (mode_r == `DHP_MODE_PACED && !ack) begin
              state_r <= ST_XFER;
            end else if (reqLow && mode_r != `DHP_MODE_PACED) begin
              // Request still low prolongs the access by whole bus cycles.
              state_r <= ST_HOLD;
            end else begin
              state_r <= ST_DONE;
              // Strobe and grant rise together at the same edge.
              rdN <= 1'b1;
              wrN <= 1'b1;
              dma_grant_n <= 1'b1;
              if (!isWrite_r) begin
                rxData_r <= busDataIn;
                rxPush <= 1'b1;
              end else begin
                popPulse_r <= 1'b1;
              end
            end
          end
          ST_HOLD: begin
            if (!reqLow) begin
              state_r <= ST_DONE;
              rdN <= 1'b1;
              wrN <= 1'b1;
              dma_grant_n <= 1'b1;
              if (!isWrite_r) begin
                rxData_r <= busDataIn;
                rxPush <= 1'b1;
              end else begin
                popPulse_r <= 1'b1;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
            busDataOe <= 1'b0;
            memory_select_n <= `DHP_SEL_RESET;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // dhp_port
`default_nettype wire

/* bench/dhp_port_chk.sv */
// Checker of the DMA handshake port pins.
`timescale 1ns/1ns
`default_nettype none
module dhp_port_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic [24:0] xferAddr,
  input wire logic [3:0] xferSelect,
  input wire logic dma_request_n,
  input wire logic ack,
  input wire logic busDataOe,
  input wire logic [24:0] addrOut,
  input wire logic [3:0] memory_select_n,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic dma_grant_n,
  input wire logic bus_clock_output,
  input wire logic busy
);
  // ****
  // Strobe and grant sequencing.
  // ****
  wire logic off = rdN & wrN;
  wire logic pace = mode == 2'h2;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  start_req_a: assert property (
    $fell(off) |-> !$past(dma_request_n, 3)) else $error("strobe without request");
  hold_off_a: assert property (
    $fell(bus_clock_output) && !$past(off) && !pace |-> off == $past(dma_request_n, 3))
    else $error("bad hold-off");
  paced_ack_a: assert property (
    $fell(bus_clock_output) && !$past(off) && pace |-> off == $past(ack))
    else $error("bad paced end");
  paced_grant_a: assert property (
    pace && busy |-> dma_grant_n) else $error("grant in paced mode");
  grant_pair_a: assert property (
    !pace |-> dma_grant_n == off) else $error("grant apart from strobe");
  strobe_width_a: assert property (
    $fell(off) |-> !off [*4]) else $error("short strobe");
  wind_down_a: assert property (
    $rose(off) |-> busy ##4 !busy && !busDataOe && memory_select_n == 4'hF)
    else $error("bad wind-down");
  addr_sel_a: assert property (
    !off |-> (mode == 2'h0 ? memory_select_n == 4'hF
      : (addrOut == xferAddr && memory_select_n == xferSelect))) else $error("bad address");
endmodule // dhp_port_chk
bind dhp_port dhp_port_chk chk (.clock, .rst, .mode, .xferAddr, .xferSelect, .dma_request_n,
  .ack, .busDataOe, .addrOut, .memory_select_n, .rdN, .wrN, .dma_grant_n, .bus_clock_output,
  .busy);
`default_nettype wire

/* bench/dhp_peer.sv */
// Model of the peripheral that requests DMA transfers.
`timescale 1ns/1ns
`default_nettype none
module dhp_peer (
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] hold,
  input wire logic [31:0] word,
  input wire logic rdN,
  input wire logic wrN,
  output logic dma_request_n,
  output logic ack,
  output logic [31:0] busDataIn
);
  // ****
  // Request, acknowledge and read data.
  // ****
  int lowCnt = 0;
  int ackCnt = 0;
  always @(posedge clock) begin
    lowCnt <= go ? 4 + 4 * hold : (lowCnt > 0 ? lowCnt - 1 : 0);
    ackCnt <= (rdN & wrN) ? 0 : ackCnt + 1;
  end
  assign dma_request_n = lowCnt == 0;
  assign ack = !(rdN & wrN) && ackCnt >= 4 * hold;
  assign busDataIn = rdN ? ~word : word;
endmodule // dhp_peer
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the DMA handshake port.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock = 0, rst = 1, xferWrite = 0, wrValid = 0, rdReady = 0, go = 0;
  logic [1:0] mode = 0;
  logic [3:0] hold = 0, xferSelect = 0, memory_select_n;
  logic [24:0] xferAddr = 0, addrOut;
  logic [31:0] word = 0, wrData = 0, busDataIn, busDataOut, rdData, wq[$], rq[$];
  logic dma_request_n, ack, busDataOe, rdN, wrN, dma_grant_n, bus_clock_output;
  logic wrReady, rdValid, busy;
  int err_total = 0, n_tests = 0;
  always #50 clock = ~clock;
  dhp_port DUT (.clock, .rst, .mode, .xferWrite, .xferAddr, .xferSelect, .dma_request_n,
    .ack, .busDataIn, .busDataOut, .busDataOe, .addrOut, .memory_select_n, .rdN, .wrN,
    .dma_grant_n, .bus_clock_output, .wrData, .wrValid, .wrReady, .rdData, .rdValid,
    .rdReady, .busy);
  dhp_peer peer (.clock, .go, .hold, .word, .rdN, .wrN, .dma_request_n, .ack, .busDataIn);
  // ****
  // Tasks.
  // ****
  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [1:0] m);
    int t;
    mode = m;
    xferWrite = w;
    {xferSelect, xferAddr} = 29'($urandom);
    hold = 4'($urandom_range(2));
    word = $urandom;
    if (!w) rq.push_back(word);
    go = 1;
    #100 go = 0;
    for (t = 0; !busy && t < 20; t++)
      #100;
    if (!busy) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, busy, 1'b1);
    end
    for (t = 0; busy && t < 200; t++)
      #100;
    if (busy) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, busy, 1'b0);
    end
    #1200;
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // Result monitor, stimulus and watchdog.
  // ****
  always @(posedge clock) begin
    if (!rst && $rose(wrN)) cmp($sampled(busDataOut), wq.pop_front());
    if (!rst && $sampled(rdValid && rdReady)) cmp($sampled(rdData), rq.pop_front());
  end
  initial begin
    void'($urandom(24));
    #751 rst = 0;
    wrValid = 1;
    repeat (40) begin
      wrData = $urandom;
      #98 if (wrReady) wq.push_back(wrData);
      #2;
    end
    wrValid = 0;
    cmp(32'(wq.size()), 32);
    $display("test fill done");
    for (int i = 0; i < 32; i++)
      xfer(1, 2'(i % 3));
    $display("test write done");
    for (int i = 0; i < 12; i++)
      xfer(0, 2'(i % 3));
    rdReady = 1;
    #2000;
    cmp(32'(wq.size() + rq.size()), 0);
    $display("test read done");
    close_out();
  end
  initial begin
    #600000;
    err_total++;
    close_out();
  end
endmodule // tb
`default_nettype wire
